/* rpg_pkg.sv */
package rpg_pkg;
  localparam logic [7:0] TERM_DISCH_OFFSET   = 8'had;
  localparam logic [7:0] RAIL_CTRL_OFFSET    = 8'hae;
  localparam logic [7:0] GOOD_A_OFFSET       = 8'hb0;
  localparam logic [7:0] GOOD_B_OFFSET       = 8'hb1;
  localparam int         TERM_DISCH_BIT      = 4;
  localparam int         DISCH_SEL_MSB       = 7;
  localparam int         DISCH_SEL_LSB       = 6;
  localparam int         OFF_CONFIG_BIT      = 5;
  localparam int         VCODE_MSB           = 4;
  localparam int         VCODE_LSB           = 1;
  localparam int         ENABLE_BIT          = 0;
  localparam logic [7:0] GOOD_RESET          = 8'h00;
  localparam logic [7:0] GOOD_B_MASK         = 8'h3f;
  localparam logic [7:0] TERM_DISCH_RESET    = 8'h5f;
  localparam logic [7:0] RAIL_CTRL_RESET     = 8'h54;
  localparam int         CLOCK_HZ            = 25000000;
  localparam int         OFF_MS_0            = 1;
  localparam int         OFF_MS_1            = 5;
  localparam int         OFF_MS_2            = 10;
  localparam int         OFF_MS_3            = 100;
  localparam int         MS_CYCLES           = CLOCK_HZ / 1000;
  typedef enum logic [1:0] {
    DISCH_NONE = 2'h0,
    DISCH_100  = 2'h1,
    DISCH_200  = 2'h2,
    DISCH_500  = 2'h3
  } rpg_disch_t;
  typedef enum logic [1:0] {
    RPG_RUN = 2'h1,
    RPG_OFF = 2'h2
  } rpg_state_t;
endpackage : rpg_pkg

/* rpg_sync_if.sv */
interface rpg_sync_if #(parameter int W = 14);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport syn (input raw, output synced);
endinterface : rpg_sync_if

/* rpg_sync.sv */
module rpg_sync #(
  parameter int W = 14
) (
  input wire logic clock,
  input wire logic reset_n,
  rpg_sync_if.syn  sio
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= sio.raw;
      sync_reg <= meta_reg;
    end
  end
  assign sio.synced = sync_reg;
endmodule : rpg_sync

/* rpg_regs.sv */
module rpg_regs #(
  parameter int OFF_CYCLES_PER_MS = rpg_pkg::MS_CYCLES
) (
  input  wire logic       CLOCK,
  input  wire logic       RESET_N,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WRITE,
  output logic      [7:0] REG_RDATA,
  input  wire logic [1:0] OTP_OFF_TIME_SEL,
  input  wire logic       OTP_LDO_IN_SEQUENCE,
  input  wire logic       OTP_SWITCHES_MERGED,
  input  wire logic       EMERGENCY_SHUTDOWN,
  input  wire logic [7:0] RAIL_GOOD_A,
  input  wire logic [5:0] RAIL_GOOD_B,
  output logic            TERM_DISCHARGE_ON,
  output logic      [1:0] GEN_LDO_DISCHARGE_SEL,
  output logic      [3:0] GEN_LDO_VOLTAGE_CODE,
  output logic            GEN_LDO_ON,
  output logic            LOAD_SWITCH_TWO_ON
);
  logic [7:0]  term_reg;
  logic [7:0]  rail_reg;
  logic [7:0]  good_a_reg;
  logic [7:0]  good_b_reg;
  logic        off_cfg;
  logic        rail_en;
  logic        esd_sync;
  logic        esd_prev_reg;
  logic        target_switch;
  logic [31:0] off_cnt_reg;
  logic [31:0] off_len;
  rpg_pkg::rpg_state_t state_reg;
  rpg_sync_if #(.W(15)) sio ();

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign sio.raw = {EMERGENCY_SHUTDOWN, RAIL_GOOD_B, RAIL_GOOD_A};
  rpg_sync #(.W(15)) u_sync (
    .clock   (CLOCK),
    .reset_n (RESET_N),
    .sio     (sio)
  );
  assign esd_sync = sio.synced[14];

  //////////////////////////////////////////////////////////////////////////
  // writable registers; reserved bits stored as the host wrote them
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      term_reg <= rpg_pkg::TERM_DISCH_RESET;
    end else if (REG_WRITE && REG_ADDR == rpg_pkg::TERM_DISCH_OFFSET) begin
      term_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rail_reg <= rpg_pkg::RAIL_CTRL_RESET;
    end else if (REG_WRITE && REG_ADDR == rpg_pkg::RAIL_CTRL_OFFSET) begin
      rail_reg <= REG_WDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // live power-good mirrors, never written by the host
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      good_a_reg <= rpg_pkg::GOOD_RESET;
      good_b_reg <= rpg_pkg::GOOD_RESET;
    end else begin
      good_a_reg <= sio.synced[7:0];
      good_b_reg <= {2'h0, sio.synced[13:8]} & rpg_pkg::GOOD_B_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    case (REG_ADDR)
      rpg_pkg::TERM_DISCH_OFFSET: REG_RDATA = term_reg;
      rpg_pkg::RAIL_CTRL_OFFSET:  REG_RDATA = rail_reg;
      rpg_pkg::GOOD_A_OFFSET:     REG_RDATA = good_a_reg;
      rpg_pkg::GOOD_B_OFFSET:     REG_RDATA = good_b_reg;
      default:                    REG_RDATA = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // emergency shutdown off window
  always_comb begin
    case (OTP_OFF_TIME_SEL)
      2'h0:    off_len = rpg_pkg::OFF_MS_0 * OFF_CYCLES_PER_MS;
      2'h1:    off_len = rpg_pkg::OFF_MS_1 * OFF_CYCLES_PER_MS;
      2'h2:    off_len = rpg_pkg::OFF_MS_2 * OFF_CYCLES_PER_MS;
      default: off_len = rpg_pkg::OFF_MS_3 * OFF_CYCLES_PER_MS;
    endcase
  end

  assign off_cfg = rail_reg[rpg_pkg::OFF_CONFIG_BIT];
  assign rail_en = rail_reg[rpg_pkg::ENABLE_BIT];

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      esd_prev_reg <= 1'b0;
    end else begin
      esd_prev_reg <= esd_sync;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_reg   <= rpg_pkg::RPG_RUN;
      off_cnt_reg <= '0;
    end else begin
      case (state_reg)
        rpg_pkg::RPG_RUN: begin
          if (esd_sync && !esd_prev_reg && !off_cfg) begin
            state_reg   <= rpg_pkg::RPG_OFF;
            off_cnt_reg <= off_len;
          end
        end
        rpg_pkg::RPG_OFF: begin
          if (off_cfg || off_cnt_reg <= 32'h1) begin
            state_reg   <= rpg_pkg::RPG_RUN;
            off_cnt_reg <= '0;
          end else begin
            off_cnt_reg <= off_cnt_reg - 32'h1;
          end
        end
        default: begin
          state_reg   <= rpg_pkg::RPG_RUN;
          off_cnt_reg <= '0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign target_switch = OTP_LDO_IN_SEQUENCE && !OTP_SWITCHES_MERGED;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      TERM_DISCHARGE_ON     <= 1'b0;
      GEN_LDO_DISCHARGE_SEL <= rpg_pkg::DISCH_NONE;
      GEN_LDO_VOLTAGE_CODE  <= 4'h0;
      GEN_LDO_ON            <= 1'b0;
      LOAD_SWITCH_TWO_ON    <= 1'b0;
    end else begin
      TERM_DISCHARGE_ON     <= term_reg[rpg_pkg::TERM_DISCH_BIT];
      GEN_LDO_DISCHARGE_SEL <= rail_reg[rpg_pkg::DISCH_SEL_MSB:rpg_pkg::DISCH_SEL_LSB];
      GEN_LDO_VOLTAGE_CODE  <= rail_reg[rpg_pkg::VCODE_MSB:rpg_pkg::VCODE_LSB];
      // config bit set overrides a running off window at once
      GEN_LDO_ON            <= !target_switch && rail_en
                               && (off_cfg || state_reg != rpg_pkg::RPG_OFF);
      LOAD_SWITCH_TWO_ON    <= target_switch && rail_en
                               && (off_cfg || state_reg != rpg_pkg::RPG_OFF);
    end
  end
endmodule : rpg_regs

/* rpg_host.sv */
module rpg_host (
  input  wire logic       clk,
  input  wire logic [7:0] q,
  output logic      [7:0] a,
  output logic      [7:0] d,
  output logic            w
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {a, d, w} = 17'h0;
  // caller passes factory values for reserved bits
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk) {a, d, w} = {ad, dt, 1'b1};
    // released data shows a changed pattern
    @(negedge clk) {d, w} = {~dt, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    @(negedge clk) a = ad;
    @(posedge clk) v = q;
  endtask : rd
endmodule : rpg_host

/* rpg_properties.sv */
module rpg_chk (
  input wire logic       CLOCK,
  input wire logic       RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WRITE,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] RAIL_GOOD_A,
  input wire logic       TERM_DISCHARGE_ON,
  input wire logic [1:0] GEN_LDO_DISCHARGE_SEL,
  input wire logic [3:0] GEN_LDO_VOLTAGE_CODE,
  input wire logic       GEN_LDO_ON,
  input wire logic       LOAD_SWITCH_TWO_ON
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  wire wa = REG_WRITE && REG_ADDR == 8'hae;
  wire wt = REG_WRITE && REG_ADDR == 8'had;
  chk_code_applied: assert property (wa ##1 !REG_WRITE |-> ##1
    GEN_LDO_VOLTAGE_CODE == $past(REG_WDATA[4:1], 2)) else $error("code");
  chk_sel_applied: assert property (wa ##1 !REG_WRITE |-> ##1
    GEN_LDO_DISCHARGE_SEL == $past(REG_WDATA[7:6], 2)) else $error("sel");
  chk_term_applied: assert property (wt ##1 !REG_WRITE |-> ##1
    TERM_DISCHARGE_ON == $past(REG_WDATA[4], 2)) else $error("term");
  chk_enable_only: assert property (wa && REG_WDATA[5] ##1 !REG_WRITE |-> ##1
    (GEN_LDO_ON | LOAD_SWITCH_TWO_ON) == $past(REG_WDATA[0], 2)) else $error("enable");
  chk_ctrl_readback: assert property (wa ##1 REG_ADDR == 8'hae |->
    REG_RDATA == $past(REG_WDATA)) else $error("readback");
  chk_term_readback: assert property (wt ##1 REG_ADDR == 8'had |->
    REG_RDATA == $past(REG_WDATA)) else $error("term readback");
  chk_b_reserved: assert property (REG_ADDR == 8'hb1 |-> REG_RDATA[7:6] == 2'h0)
    else $error("status b");
  chk_status_a: assert property ((REG_ADDR == 8'hb0 && $stable(RAIL_GOOD_A))[*5]
    |-> REG_RDATA == RAIL_GOOD_A) else $error("status a");
endmodule : rpg_chk
bind rpg_regs rpg_chk u_chk (.*);

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       CLOCK = 1'b0;
  logic       RESET_N, esd, w;
  logic       seq = 1'b1;
  logic [7:0] a, d, q, ga, rv;
  logic [5:0] gb;
  logic [8:0] o;
  int         bad_count, checks, n;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
  rpg_regs #(.OFF_CYCLES_PER_MS(10)) u_dut (.CLOCK, .RESET_N, .REG_ADDR(a), .REG_WDATA(d),
    .REG_WRITE(w), .REG_RDATA(q), .OTP_OFF_TIME_SEL(2'h1), .OTP_LDO_IN_SEQUENCE(seq),
    .OTP_SWITCHES_MERGED(1'b0), .EMERGENCY_SHUTDOWN(esd), .RAIL_GOOD_A(ga), .RAIL_GOOD_B(gb),
    .TERM_DISCHARGE_ON(o[8]), .GEN_LDO_DISCHARGE_SEL(o[7:6]), .GEN_LDO_VOLTAGE_CODE(o[5:2]),
    .GEN_LDO_ON(o[1]), .LOAD_SWITCH_TWO_ON(o[0]));
  rpg_host u_host (.clk(CLOCK), .q, .a, .d, .w);
  initial forever #20 CLOCK = ~CLOCK;
  initial begin
    repeat (1000) @(posedge CLOCK);
    bad_count++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic rc(input logic [7:0] ad, input logic [7:0] ex);
    u_host.rd(ad, rv);
    `CHK(rv, ex)
  endtask : rc
  initial begin
    {RESET_N, esd, ga, gb} = 16'h0;
    repeat (6) @(negedge CLOCK);
    RESET_N = 1'b1;
    rc(8'had, 8'h5f);
    rc(8'hae, 8'h54);
    `CHK(o, 9'h168)
    $display("reset test done");
    u_host.wr(8'had, 8'h4f);
    for (n = 0; n < 4; n++) begin
      u_host.wr(8'hae, {n[1:0], 1'b0, 4'(n * 5), 1'b0});
      repeat (2) @(negedge CLOCK);
      `CHK(o, {1'b0, n[1:0], 4'(n * 5), 2'b00})
    end
    u_host.wr(8'hae, 8'h21);
    esd = 1'b1;
    repeat (8) @(negedge CLOCK);
    `CHK(o[1:0], 2'b01)
    esd = 1'b0;
    u_host.wr(8'hae, 8'h01);
    esd = 1'b1;
    n = 0;
    // off window is five units of ten cycles
    repeat (80) @(negedge CLOCK) n += int'(o[0] === 1'b0);
    `CHK(n, 50)
    $display("control tests done");
    esd = 1'b0;
    {ga, gb} = {8'ha5, 6'h2a};
    u_host.wr(8'hb0, 8'hff);
    repeat (6) @(negedge CLOCK);
    rc(8'hb0, 8'ha5);
    rc(8'hb1, 8'h2a);
    $display("status tests done");
    // ldo not sequenced: enable moves to the general ldo
    seq = 1'b0;
    repeat (2) @(negedge CLOCK);
    `CHK(o[1:0], 2'b10)
    $display("target tests done");
    report_and_stop();
  end
endmodule : testbench
